// ===== src/adc_readout_pkg.sv
package adc_readout_pkg;

  // ==========================================================================
  // Widths
  // ==========================================================================
  localparam int RESULT_W = 16;
  localparam int CNT_W    = 5;
  localparam int TICK_W   = 8;
  localparam int ADDR_W   = 4;
  localparam int DATA_W   = 32;

  // ==========================================================================
  // Register byte offsets
  // ==========================================================================
  localparam logic [ADDR_W-1:0] OFS_CTRL   = 4'h0;
  localparam logic [ADDR_W-1:0] OFS_STATUS = 4'h4;
  localparam logic [ADDR_W-1:0] OFS_RESULT = 4'h8;

  // ==========================================================================
  // Field positions in the status word
  // ==========================================================================
  localparam int ST_BUSY_BIT    = 0;
  localparam int ST_OVERRUN_BIT = 1;
  localparam int ST_MASTER_BIT  = 2;
  localparam int ST_COUNT_LSB   = 4;

  // ==========================================================================
  // Control word layout and reset value
  // ==========================================================================
  typedef struct packed {
    logic       slave_rdc;
    logic       straight_binary;
    logic       sync_invert;
    logic       sclk_invert;
    logic [1:0] clock_divider_select;
    logic       clock_source_select;
    logic       byte_order_swap;
    logic       serial_parallel_select;
  } ctrl_t;

  localparam int    CTRL_W     = 9;
  localparam ctrl_t CTRL_RESET = 9'h000;

  // ==========================================================================
  // Serial timing
  // ==========================================================================
  localparam logic [CNT_W-1:0]  BITS_PER_WORD = 5'h10;
  localparam logic [CNT_W-1:0]  LAST_BIT      = 5'h0F;
  localparam logic [TICK_W-1:0] MST_TICK_BASE = 8'h01;
  localparam logic [1:0]        PH_DATA       = 2'h0;
  localparam logic [1:0]        PH_RISE       = 2'h1;
  localparam logic [1:0]        PH_HIGH       = 2'h2;
  localparam logic [1:0]        PH_FALL       = 2'h3;

  typedef enum logic [1:0] {
    MST_IDLE  = 2'b01,
    MST_SHIFT = 2'b10
  } mst_state_t;

endpackage

// ===== src/adc_result_readout_port.sv
// Chosen here: register access over Avalon-MM and the register addresses.
`timescale 1ns/1ps
// Operation
// - Select low: result on parallel bus
// - Parallel read after or during conversion
// - No swap: low byte D[7:0]
// - Swap: low byte on D[15:8]
// - Serial: sixteen bits, MSB first
// - Master: device drives clock and frame
// - Master clock and frame polarity selectable
// - Master bit stable across both edges
// - Timing pin picks after or during
// - Master after-read: busy until shifted
// - Master clock divided by select field
// - Slave: host supplies serial clock
// - Slave clock gated by selects low
// - Slave clock continuous or idle either
// - Slave after-read: clock out after busy
// - Chain input sampled on opposite edge
// - Unfinished slave during-read flags overrun
// - Slave read may span next conversion
// - Outputs disabled unless both selects low
// - Result coding selectable two forms
// - Started conversion never restarted or aborted
module adc_result_readout_port
  import adc_readout_pkg::*;
#(
  parameter logic [TICK_W-1:0] TICK_BASE = MST_TICK_BASE
) (
  input  wire logic                CLK,
  input  wire logic                RST_N,
  input  wire logic [ADDR_W-1:0]   AVS_ADDRESS,
  input  wire logic                AVS_READ,
  input  wire logic                AVS_WRITE,
  input  wire logic [DATA_W-1:0]   AVS_WRITEDATA,
  input  wire logic [3:0]          AVS_BYTEENABLE,
  output logic      [DATA_W-1:0]   AVS_READDATA,
  output logic                     AVS_WAITREQUEST,
  input  wire logic                CONVERT_START_N,
  input  wire logic                POWER_DOWN,
  output logic                     CONV_START,
  input  wire logic                CORE_DONE,
  input  wire logic [RESULT_W-1:0] CORE_DATA,
  output logic                     BUSY,
  input  wire logic                CS_N,
  input  wire logic                RD_N,
  output logic      [RESULT_W-1:0] D_OUT,
  output logic                     D_OE,
  output logic                     SERIAL_DATA_OUT,
  output logic                     SERIAL_DATA_OE,
  input  wire logic                SCLK_IN,
  output logic                     SCLK_OUT,
  output logic                     SCLK_OE,
  output logic                     SYNC_OUT,
  output logic                     SYNC_OE,
  input  wire logic                READ_TIMING_CHAIN_IN,
  output logic                     READ_OVERRUN_FLAG
);

  // ==========================================================================
  // Reset release
  // ==========================================================================
  logic [1:0] rst_sync_ff;
  wire        rst_n = rst_sync_ff[1];

  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      rst_sync_ff <= 2'h0;
    end else begin
      rst_sync_ff <= {rst_sync_ff[0], 1'b1};
    end
  end

  // ==========================================================================
  // Declarations
  // ==========================================================================
  ctrl_t               ctrl_ff;
  logic                ack_ff;
  logic [DATA_W-1:0]   rd_data_ff;
  logic                cnv_d_ff;
  logic                conv_ff;
  logic                conv_start_ff;
  logic [RESULT_W-1:0] result_ff;
  logic [RESULT_W-1:0] d_out_ff;
  logic [RESULT_W-1:0] shift_ff;
  logic [CNT_W-1:0]    cnt_ff;
  logic                chain_bit_ff;
  logic                sclk_d_ff;
  logic                slv_sel_d_ff;
  logic                ovr_pulse_ff;
  logic                ovr_sticky_ff;
  mst_state_t          mst_state_ff;
  logic [1:0]          phase_ff;
  logic [TICK_W-1:0]   tick_ff;

  // ==========================================================================
  // Mode decode
  // ==========================================================================
  wire serial_mode = ctrl_ff.serial_parallel_select;
  wire slave_mode  = serial_mode & ctrl_ff.clock_source_select;
  wire master_mode = serial_mode & ~ctrl_ff.clock_source_select;
  wire sel_low     = ~CS_N & ~RD_N;
  // Pin level high means shift the previous word during conversion
  wire mst_during  = READ_TIMING_CHAIN_IN;
  wire mst_active  = (mst_state_ff == MST_SHIFT);

  // ==========================================================================
  // Register bus
  // ==========================================================================
  // One wait state: every access is answered on the second cycle
  wire req         = AVS_READ | AVS_WRITE;
  wire wr_commit   = AVS_WRITE & ack_ff;
  wire hit_ctrl    = (AVS_ADDRESS == OFS_CTRL);
  wire hit_status  = (AVS_ADDRESS == OFS_STATUS);
  wire hit_result  = (AVS_ADDRESS == OFS_RESULT);
  wire wr_ctrl_lo  = wr_commit & hit_ctrl & AVS_BYTEENABLE[0];
  wire wr_ctrl_hi  = wr_commit & hit_ctrl & AVS_BYTEENABLE[1];
  wire ovr_clear   = wr_commit & hit_status & AVS_BYTEENABLE[0] & AVS_WRITEDATA[ST_OVERRUN_BIT];

  wire [DATA_W-1:0] status_word = DATA_W'({cnt_ff, 1'b0, mst_active, ovr_sticky_ff, BUSY})
                                  << 0;
  wire [DATA_W-1:0] status_mux  = {status_word[DATA_W-1:ST_COUNT_LSB+CNT_W],
                                   status_word[CNT_W+3:4],
                                   1'b0,
                                   status_word[2:0]};
  wire [DATA_W-1:0] rd_mux      = hit_ctrl   ? DATA_W'(ctrl_ff) :
                                  hit_status ? status_mux :
                                  hit_result ? DATA_W'(result_ff) :
                                  32'h0000_0000;

  assign AVS_WAITREQUEST = req & ~ack_ff;
  assign AVS_READDATA    = rd_data_ff;

  always_ff @(posedge CLK or negedge rst_n) begin
    if (!rst_n) begin
      ack_ff     <= 1'b0;
      rd_data_ff <= 32'h0000_0000;
    end else begin
      ack_ff     <= req & ~ack_ff;
      rd_data_ff <= (AVS_READ & ~ack_ff) ? rd_mux : rd_data_ff;
    end
  end

  wire [CTRL_W-1:0] ctrl_bits   = ctrl_ff;
  wire [CTRL_W-1:0] nxt_ctrl    = {wr_ctrl_hi ? AVS_WRITEDATA[8] : ctrl_bits[8],
                                   wr_ctrl_lo ? AVS_WRITEDATA[7:0] : ctrl_bits[7:0]};

  always_ff @(posedge CLK or negedge rst_n) begin
    if (!rst_n) begin
      ctrl_ff <= CTRL_RESET;
    end else begin
      ctrl_ff <= ctrl_t'(nxt_ctrl);
    end
  end

  // ==========================================================================
  // Conversion control
  // ==========================================================================
  // A start edge during a conversion or a held busy is ignored, and power-down
  // only blocks new starts, so a running conversion always finishes
  wire start_edge = cnv_d_ff & ~CONVERT_START_N;
  wire start_ok   = start_edge & ~BUSY & ~POWER_DOWN;
  wire nxt_conv   = start_ok | (conv_ff & ~CORE_DONE);

  // Straight binary flips the sign bit of the core's two's complement word
  wire [RESULT_W-1:0] coded = {CORE_DATA[RESULT_W-1] ^ ctrl_ff.straight_binary,
                               CORE_DATA[RESULT_W-2:0]};
  wire done_now = conv_ff & CORE_DONE;

  assign BUSY       = conv_ff | (mst_active & ~mst_during);
  assign CONV_START = conv_start_ff;

  always_ff @(posedge CLK or negedge rst_n) begin
    if (!rst_n) begin
      cnv_d_ff      <= 1'b1;
      conv_ff       <= 1'b0;
      conv_start_ff <= 1'b0;
      result_ff     <= 16'h0000;
    end else begin
      cnv_d_ff      <= CONVERT_START_N;
      conv_ff       <= nxt_conv;
      conv_start_ff <= start_ok;
      result_ff     <= done_now ? coded : result_ff;
    end
  end

  // ==========================================================================
  // Parallel bus
  // ==========================================================================
  // The word is valid at any time, so reads after or during conversion both work
  wire [RESULT_W-1:0] nxt_d_out = ctrl_ff.byte_order_swap ?
                                  {result_ff[7:0], result_ff[15:8]} :
                                  result_ff;

  always_ff @(posedge CLK or negedge rst_n) begin
    if (!rst_n) begin
      d_out_ff <= 16'h0000;
    end else begin
      d_out_ff <= nxt_d_out;
    end
  end

  assign D_OUT = d_out_ff;
  assign D_OE  = ~serial_mode & sel_low;

  // ==========================================================================
  // Master serial clock divider
  // ==========================================================================
  wire [TICK_W-1:0] tick_max = TICK_W'((TICK_BASE << ctrl_ff.clock_divider_select) - 8'h01);
  wire              tick     = mst_active & (tick_ff == tick_max);

  always_ff @(posedge CLK or negedge rst_n) begin
    if (!rst_n) begin
      tick_ff <= 8'h00;
    end else begin
      tick_ff <= (!mst_active || tick) ? 8'h00 : TICK_W'(tick_ff + 8'h01);
    end
  end

  // ==========================================================================
  // Serial shifter, master and slave
  // ==========================================================================
  wire mst_go    = master_mode & ~mst_active &
                   ((mst_during & start_ok) | (~mst_during & done_now));
  wire mst_step  = tick & (phase_ff == PH_FALL);
  wire mst_end   = mst_step & (cnt_ff == LAST_BIT);

  wire slv_sel   = slave_mode & sel_low;
  wire slv_open  = slv_sel & ~slv_sel_d_ff;
  // Edges are seen only while chip select is low; both idle levels work
  wire sclk_rise = ~CS_N & SCLK_IN & ~sclk_d_ff;
  wire sclk_fall = ~CS_N & ~SCLK_IN & sclk_d_ff;
  wire slv_shift = slv_sel & sclk_fall;
  wire slv_idle  = (cnt_ff == 5'h00) | (cnt_ff == BITS_PER_WORD);
  // A read in progress keeps its word when the next result lands
  wire slv_load  = slave_mode & done_now & slv_idle;
  wire ovr_set   = slave_mode & ctrl_ff.slave_rdc & done_now & ~slv_idle;

  wire [CNT_W-1:0] cnt_inc = (cnt_ff == BITS_PER_WORD) ? cnt_ff : CNT_W'(cnt_ff + 5'h01);

  mst_state_t          nxt_mst_state;
  logic [RESULT_W-1:0] nxt_shift;
  logic [CNT_W-1:0]    nxt_cnt;

  always_comb begin
    nxt_mst_state = mst_state_ff;
    nxt_shift     = shift_ff;
    nxt_cnt       = cnt_ff;
    unique case (mst_state_ff)
      MST_IDLE: begin
        if (mst_go) begin
          nxt_mst_state = MST_SHIFT;
          nxt_shift     = mst_during ? result_ff : coded;
          nxt_cnt       = 5'h00;
        end else if (slv_load) begin
          nxt_shift = coded;
          nxt_cnt   = 5'h00;
        end else if (slv_open) begin
          nxt_shift = result_ff;
          nxt_cnt   = 5'h00;
        end else if (slv_shift) begin
          // Chain bits keep flowing after the word for cascaded parts
          nxt_shift = {shift_ff[RESULT_W-2:0], chain_bit_ff};
          nxt_cnt   = cnt_inc;
        end
      end
      MST_SHIFT: begin
        if (mst_end) begin
          nxt_mst_state = MST_IDLE;
          nxt_cnt       = BITS_PER_WORD;
        end else if (mst_step) begin
          nxt_shift = {shift_ff[RESULT_W-2:0], 1'b0};
          nxt_cnt   = cnt_inc;
        end
      end
    endcase
  end

  always_ff @(posedge CLK or negedge rst_n) begin
    if (!rst_n) begin
      mst_state_ff <= MST_IDLE;
      shift_ff     <= 16'h0000;
      cnt_ff       <= 5'h00;
    end else begin
      mst_state_ff <= nxt_mst_state;
      shift_ff     <= nxt_shift;
      cnt_ff       <= nxt_cnt;
    end
  end

  // Data moves one tick before the rising edge and one tick after the falling
  // edge, so either edge samples a settled bit
  always_ff @(posedge CLK or negedge rst_n) begin
    if (!rst_n) begin
      phase_ff <= PH_DATA;
    end else begin
      phase_ff <= !mst_active ? PH_DATA : (tick ? 2'(phase_ff + 2'h1) : phase_ff);
    end
  end

  // ==========================================================================
  // Slave edge tracking and chain capture
  // ==========================================================================
  // Only the after-conversion slave mode accepts chained data
  wire chain_on = slave_mode & ~ctrl_ff.slave_rdc;

  always_ff @(posedge CLK or negedge rst_n) begin
    if (!rst_n) begin
      sclk_d_ff    <= 1'b0;
      slv_sel_d_ff <= 1'b0;
      chain_bit_ff <= 1'b0;
    end else begin
      sclk_d_ff    <= SCLK_IN;
      slv_sel_d_ff <= slv_sel;
      chain_bit_ff <= !chain_on ? 1'b0 :
                      (sclk_rise ? READ_TIMING_CHAIN_IN : chain_bit_ff);
    end
  end

  // ==========================================================================
  // Overrun flag
  // ==========================================================================
  // Set beats a simultaneous clear so no overrun is lost
  always_ff @(posedge CLK or negedge rst_n) begin
    if (!rst_n) begin
      ovr_pulse_ff  <= 1'b0;
      ovr_sticky_ff <= 1'b0;
    end else begin
      ovr_pulse_ff  <= ovr_set;
      ovr_sticky_ff <= ovr_set | (ovr_sticky_ff & ~ovr_clear);
    end
  end

  assign READ_OVERRUN_FLAG = ovr_pulse_ff;

  // ==========================================================================
  // Serial pins
  // ==========================================================================
  wire mst_sclk = mst_active & ((phase_ff == PH_RISE) | (phase_ff == PH_HIGH));

  assign SERIAL_DATA_OUT = shift_ff[RESULT_W-1];
  assign SERIAL_DATA_OE  = serial_mode & sel_low;
  assign SCLK_OUT        = mst_sclk ^ ctrl_ff.sclk_invert;
  assign SYNC_OUT        = mst_active ^ ctrl_ff.sync_invert;
  assign SCLK_OE         = master_mode & sel_low;
  assign SYNC_OE         = master_mode & sel_low;

endmodule

// ===== bench/adc_readout_checker_assertions.sv
`timescale 1ns/1ps
// ========================================
// Port-level checks of the readout port
module adc_readout_checker (
  input wire logic CLK,
  input wire logic RST_N,
  input wire logic AVS_READ,
  input wire logic AVS_WRITE,
  input wire logic AVS_WAITREQUEST,
  input wire logic CONVERT_START_N,
  input wire logic POWER_DOWN,
  input wire logic CONV_START,
  input wire logic CORE_DONE,
  input wire logic BUSY,
  input wire logic CS_N,
  input wire logic RD_N,
  input wire logic D_OE,
  input wire logic SERIAL_DATA_OUT,
  input wire logic SERIAL_DATA_OE,
  input wire logic SCLK_OUT,
  input wire logic SCLK_OE,
  input wire logic SYNC_OE,
  input wire logic READ_OVERRUN_FLAG
);
  default clocking cb @(posedge CLK);
  endclocking
  default disable iff (!RST_N);

  start_pulse_a: assert property ($fell(CONVERT_START_N) && !BUSY && !POWER_DOWN |=> CONV_START && BUSY)
    else $error("start edge not answered by pulse and busy");
  busy_kept_a: assert property (BUSY && D_OE && !CORE_DONE |=> BUSY)
    else $error("busy dropped without core done");
  no_restart_a: assert property (BUSY && $past(BUSY) |-> !CONV_START)
    else $error("conversion restarted while busy");
  // One idle cycle is allowed in case the enables are registered
  oe_gate_a: assert property ((CS_N || RD_N) && $past(CS_N || RD_N) |-> !(D_OE || SERIAL_DATA_OE || SCLK_OE))
    else $error("outputs driven while deselected");
  oe_excl_a: assert property (!(D_OE && (SERIAL_DATA_OE || SCLK_OE)))
    else $error("parallel and serial drivers both on");
  master_pins_a: assert property (SCLK_OE == SYNC_OE)
    else $error("clock and frame enables differ");
  bit_stable_a: assert property (SCLK_OE && $past(SCLK_OE) && $changed(SCLK_OUT) |-> $stable(SERIAL_DATA_OUT))
    else $error("serial data moved on a clock edge");
  ovr_pulse_a: assert property (READ_OVERRUN_FLAG |=> !READ_OVERRUN_FLAG)
    else $error("overrun flag longer than one cycle");
  ovr_cause_a: assert property (READ_OVERRUN_FLAG |-> $past(CORE_DONE))
    else $error("overrun flag without conversion end");
  wait_state_a: assert property ((AVS_READ || AVS_WRITE) && AVS_WAITREQUEST |=> !AVS_WAITREQUEST)
    else $error("bus answer later than one wait state");
endmodule

bind adc_result_readout_port adc_readout_checker u_chk (.CLK, .RST_N, .AVS_READ, .AVS_WRITE, .AVS_WAITREQUEST,
  .CONVERT_START_N, .POWER_DOWN, .CONV_START, .CORE_DONE, .BUSY, .CS_N, .RD_N, .D_OE, .SERIAL_DATA_OUT,
  .SERIAL_DATA_OE, .SCLK_OUT, .SCLK_OE, .SYNC_OE, .READ_OVERRUN_FLAG);

// ===== bench/serial_host_model.sv
`timescale 1ns/1ps
// ========================================
// Host serial reader, discontinuous clock idling low
module serial_host_model (
  input  wire logic        clk,
  input  wire logic        go,
  input  wire logic [5:0]  nbits,
  input  wire logic [15:0] chain_word,
  input  wire logic        sdata,
  output logic             sclk,
  output logic             chain,
  output logic             done,
  output logic [31:0]      word
);
  logic [15:0] sh;
  initial begin
    sclk = 1'b0;
    chain = 1'b0;
    done = 1'b0;
    word = 32'h0;
  end
  // Half period of four system cycles keeps the port's edge detector happy
  always @(posedge clk) begin
    if (go) begin
      done <= 1'b0;
      sh = chain_word;
      word = 32'h0;
      for (int i = 0; i < nbits; i++) begin
        chain <= sh[15];
        repeat (4) @(posedge clk);
        sclk <= 1'b1;
        repeat (2) @(posedge clk);
        word = {word[30:0], sdata};
        repeat (2) @(posedge clk);
        sclk <= 1'b0;
        sh = {sh[14:0], 1'b0};
      end
      // Released line must not look like a valid bit
      chain <= ~chain;
      done <= 1'b1;
    end
  end
endmodule

// ===== bench/test_adc_result_readout_port.sv
`timescale 1ns/1ps
module test_adc_result_readout_port;
  import adc_readout_pkg::*;
  logic                clk, rst_n, rd, wr, wreq, cnv_n, pd, cst, cdone, busy, cs_n, rd_n, doe, sdo, sdoe;
  logic                sclk, sclk_oe, sync, sync_oe, rdc, h_tie, hch, hclk, ovr, h_go, h_done;
  logic [ADDR_W-1:0]   adr;
  logic [DATA_W-1:0]   wdat, rdat, r;
  logic [RESULT_W-1:0] cdat, dq, w, pr, cw, q;
  logic [31:0]         hw;
  logic [5:0]          h_n;
  int                  mismatches, n_checks, seed, per;

  adc_result_readout_port dut (.CLK(clk), .RST_N(rst_n), .AVS_ADDRESS(adr), .AVS_READ(rd), .AVS_WRITE(wr),
    .AVS_WRITEDATA(wdat), .AVS_BYTEENABLE(4'hF), .AVS_READDATA(rdat), .AVS_WAITREQUEST(wreq),
    .CONVERT_START_N(cnv_n), .POWER_DOWN(pd), .CONV_START(cst), .CORE_DONE(cdone), .CORE_DATA(cdat),
    .BUSY(busy), .CS_N(cs_n), .RD_N(rd_n), .D_OUT(dq), .D_OE(doe), .SERIAL_DATA_OUT(sdo),
    .SERIAL_DATA_OE(sdoe), .SCLK_IN(hclk), .SCLK_OUT(sclk), .SCLK_OE(sclk_oe), .SYNC_OUT(sync),
    .SYNC_OE(sync_oe), .READ_TIMING_CHAIN_IN(h_tie ? rdc : hch), .READ_OVERRUN_FLAG(ovr));
  serial_host_model host_m (.clk(clk), .go(h_go), .nbits(h_n), .chain_word(cw), .sdata(sdo), .sclk(hclk),
    .chain(hch), .done(h_done), .word(hw));

  always #5 clk = ~clk;

  // ========================================
  // Helpers
  function automatic logic [15:0] cod(input logic [15:0] d, input logic sb);
    return sb ? {~d[15], d[14:0]} : d;
  endfunction
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp) begin
      mismatches++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge clk);
  endtask
  task automatic print_verdict;
    $display("checks=%0d mismatches=%0d", n_checks, mismatches);
    if (mismatches == 0 && n_checks > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask
  task automatic bus(input logic we, input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
    int n;
    n = 0;
    @(posedge clk);
    adr <= a;
    wdat <= d;
    wr <= we;
    rd <= !we;
    do begin
      @(negedge clk);
      n++;
    end while (wreq !== 1'b0 && n < 40);
    r = rdat;
    chk(wreq, 1'b0);
    @(posedge clk);
    rd <= 1'b0;
    wr <= 1'b0;
  endtask
  task automatic start_conv;
    int n;
    n = 0;
    @(posedge clk);
    cnv_n <= 1'b0;
    do begin
      @(negedge clk);
      n++;
    end while (cst !== 1'b1 && n < 20);
    chk({cst, busy}, 2'h3);
    @(posedge clk);
    cnv_n <= 1'b1;
  endtask
  task automatic finish_conv(input logic [15:0] d);
    @(posedge clk);
    cdat <= d;
    cdone <= 1'b1;
    @(posedge clk);
    cdone <= 1'b0;
  endtask
  task automatic wait_idle;
    int n;
    n = 0;
    do begin
      @(negedge clk);
      n++;
    end while (busy !== 1'b0 && n < 300);
    chk(busy, 1'b0);
  endtask
  // Collects sixteen bits at rising clock edges and the spacing of the last two
  task automatic cap_m;
    int n, k, t0;
    logic s0;
    n = 0;
    k = 0;
    t0 = 0;
    s0 = 1'b0;
    while (k < 16 && n < 3000) begin
      @(negedge clk);
      n++;
      if (sclk === 1'b1 && !s0) begin
        q = {q[14:0], sdo};
        k++;
        per = n - t0;
        t0 = n;
      end
      s0 = (sclk === 1'b1);
    end
  endtask
  task automatic host(input logic [5:0] nb);
    int n;
    n = 0;
    @(posedge clk);
    h_n <= nb;
    h_go <= 1'b1;
    @(posedge clk);
    h_go <= 1'b0;
    do begin
      @(posedge clk);
      n++;
    end while (h_done !== 1'b1 && n < 400);
    chk(h_done, 1'b1);
  endtask

  initial begin
    repeat (40000) @(posedge clk);
    mismatches++;
    print_verdict;
  end

  // ========================================
  // Main sequence
  initial begin
    seed = 44;
    {clk, rst_n, rd, wr, pd, cdone, h_go, h_tie, rdc} = '0;
    {cnv_n, cs_n, rd_n} = 3'h7;
    {adr, wdat, cdat, cw, h_n, mismatches, n_checks} = '0;
    tick(2);
    rst_n <= 1'b1;
    tick(3);
    bus(0, OFS_CTRL, 0);
    chk(r, 32'(CTRL_RESET));
    bus(1, 4'hC, 32'hFFFF_FFFF);
    bus(0, 4'hC, 0);
    chk(r, 0);
    bus(0, OFS_STATUS, 0);
    chk(r, 0);
    bus(0, OFS_CTRL, 0);
    chk(r, 0);
    tick(1);
    pd <= 1'b1;
    cnv_n <= 1'b0;
    tick(3);
    @(negedge clk);
    chk(busy, 1'b0);
    tick(1);
    cnv_n <= 1'b1;
    pd <= 1'b0;
    for (int i = 0; i < 4; i++) begin
      w = $random(seed);
      bus(1, OFS_CTRL, {24'h0, i[1], 5'h0, i[0], 1'b0});
      start_conv;
      finish_conv(w);
      cs_n <= 1'b0;
      rd_n <= 1'b0;
      pr = cod(w, i[1]);
      bus(0, OFS_RESULT, 0);
      chk(r, pr);
      pr = i[0] ? {pr[7:0], pr[15:8]} : pr;
      chk({doe, dq}, {1'b1, pr});
      start_conv;
      pd <= 1'b1;
      tick(2);
      @(negedge clk);
      chk({busy, dq}, {1'b1, pr});
      finish_conv(~w);
      pd <= 1'b0;
      cs_n <= 1'b1;
      tick(2);
      @(negedge clk);
      chk(doe, 1'b0);
    end
    tick(1);
    cs_n <= 1'b0;
    for (int dv = 0; dv < 2; dv++) begin
      w = $random(seed);
      bus(1, OFS_CTRL, {27'h0, dv[1:0], 3'h1});
      fork
        begin
          start_conv;
          finish_conv(w);
        end
        cap_m;
      join
      chk(busy, 1'b1);
      chk(q, w);
      chk(per, 4 * (int'(MST_TICK_BASE) << dv));
      wait_idle;
      tick(1);
      h_tie <= 1'b1;
      rdc <= 1'b1;
      fork
        start_conv;
        cap_m;
      join
      chk(q, w);
      finish_conv(~w);
      wait_idle;
      tick(1);
      rdc <= 1'b0;
    end
    bus(1, OFS_CTRL, 32'h61);
    tick(2);
    @(negedge clk);
    chk({sclk, sync, sclk_oe}, 3'h7);
    tick(1);
    cs_n <= 1'b1;
    h_tie <= 1'b0;
    w = $random(seed);
    cw = $random(seed);
    bus(1, OFS_CTRL, 32'h5);
    start_conv;
    finish_conv(w);
    tick(2);
    cs_n <= 1'b0;
    host(6'd32);
    chk(hw, {w, cw});
    tick(1);
    cs_n <= 1'b1;
    h_tie <= 1'b1;
    bus(1, OFS_CTRL, 32'h105);
    tick(1);
    cs_n <= 1'b0;
    start_conv;
    host(6'd16);
    chk(hw[15:0], w);
    finish_conv(cw);
    bus(0, OFS_STATUS, 0);
    chk(r[1], 1'b0);
    start_conv;
    host(6'd8);
    chk(hw[7:0], cw[15:8]);
    finish_conv(w);
    @(negedge clk);
    chk(ovr, 1'b1);
    @(negedge clk);
    chk(ovr, 1'b0);
    bus(0, OFS_STATUS, 0);
    chk(r[1], 1'b1);
    bus(1, OFS_STATUS, 32'h2);
    bus(0, OFS_STATUS, 0);
    chk(r[1], 1'b0);
    print_verdict;
  end
endmodule
